// ---- pid_cfg.svh ----
`ifndef PID_CFG_SVH
`define PID_CFG_SVH

// Register indices; byte address is four times the index
`define PID_IDX_POWER 4'h4
`define PID_IDX_PAGE_SEL 4'h7
`define PID_IDX_COMPLIANCE 4'h8
`define PID_IDX_IDENT_RSVD 4'h9
`define PID_IDX_OUI_HI 4'hA
`define PID_IDX_OUI_MID 4'hB
`define PID_IDX_OUI_LO 4'hC
`define PID_IDX_PART_HI 4'hD
`define PID_IDX_PART_MID 4'hE
`define PID_IDX_PART_LO 4'hF
`define PID_IDX_VENDOR_CTRL 4'h8

// Page selector codes
`define PID_PAGE_IDENT 3'h1
`define PID_PAGE_VENDOR 3'h7

// Field positions
`define PID_HOLD_BIT 7
`define PID_SPEED_MSB 1
`define PID_SPEED_LSB 0
`define PID_PAGE_MSB 2
`define PID_PAGE_LSB 0
`define PID_POWER_MSB 2
`define PID_POWER_LSB 0

// Fixed and reset values
`define PID_COMPLIANCE_VAL 8'h01
`define PID_PAGE_RST 3'h0
`define PID_SPEED_RST 2'h2
`define PID_SPEED_ILLEGAL 2'h3
`define PID_HOLD_RST 1'b0
`define PID_POWER_RST 3'h0
`define PID_PHY_SPEED 2'h2
`define PID_ACK_BITS 16'h0008
`define PID_HSIZE_WORD 3'h2

`endif

// ---- pid_llc_model.sv ----
`timescale 1ns/100ps
module pid_llc_model (
  input wire logic mclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  task automatic xfer(input logic [31:0] a, input logic w,
    input logic [2:0] s, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= s;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule

// ---- pid_phy_id_regs.sv ----
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/100ps
`include "pid_cfg.svh"
// Functional notes
// - Page select 1 maps identification page
// - Compliance byte reads fixed 01h
// - Maker OUI, MSB first at 1010b
// - Part code, MSB first at 1101b
// - Page select 7 maps vendor page
// - Hold and acceleration: only long packets clear
// - Hold clear: any non-ACK packet clears
// - Hold bit zero on hardware reset only
// - Two-bit link speed, code 11 illegal
// - Link speed copied into self-ID speed
// - Always report S400 to peer PHYs
// - Link speed S400 on hardware reset only
// - Straps load power class after reset
// - Power-class write replaces strapped default
// - Power-class code carried unchanged
module pid_phy_id_regs
#(
  // Arbitrary value
  parameter logic [23:0] MAKER_OUI = 24'hA5C3E1,
  // Arbitrary value
  parameter logic [23:0] PART_CODE = 24'h5A3C1E
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire pid_pkg::pid_power_t powerClassStraps,
  input wire logic arbAccelEn,
  input wire logic fairReqRaise,
  input wire logic prioReqRaise,
  input wire logic pktDone,
  input wire logic [15:0] pktDataBits,
  output logic fairReqPending,
  output logic prioReqPending,
  output pid_pkg::pid_page_t pageSelect,
  output pid_pkg::pid_speed_t selfIdSpeed,
  output pid_pkg::pid_speed_t peerPhySpeed,
  output pid_pkg::pid_power_t selfIdPower
);
  import pid_pkg::*;

  // Paged slot decode, shared by read and write paths
  function automatic logic pagedHit
  (
    input logic [3:0] idx,
    input pid_page_t page,
    input pid_page_t wantPage,
    input logic [3:0] wantIdx
  );
    pagedHit = (page == wantPage) && (idx == wantIdx);
  endfunction

  // Identification page contents by index
  function automatic logic [7:0] identByte
  (
    input logic [3:0] idx,
    input logic [23:0] oui,
    input logic [23:0] part
  );
    case (idx)
      `PID_IDX_COMPLIANCE:
      begin
        identByte = `PID_COMPLIANCE_VAL;
      end
      `PID_IDX_OUI_HI:
      begin
        identByte = oui[23:16];
      end
      `PID_IDX_OUI_MID:
      begin
        identByte = oui[15:8];
      end
      `PID_IDX_OUI_LO:
      begin
        identByte = oui[7:0];
      end
      `PID_IDX_PART_HI:
      begin
        identByte = part[23:16];
      end
      `PID_IDX_PART_MID:
      begin
        identByte = part[15:8];
      end
      `PID_IDX_PART_LO:
      begin
        identByte = part[7:0];
      end
      default:
      begin
        identByte = 8'h00;
      end
    endcase
  endfunction

  pid_bus_state_t busState;
  pid_bus_state_t next_busState;
  logic [3:0] addrIdx;
  logic addrHit;
  logic addrWord;
  logic nullPacketHold;
  logic strapLoaded;
  pid_speed_t linkSpeed;
  pid_power_t powerClass;

  wire logic takeReq;
  wire logic reqHit;
  wire logic wrCommit;
  wire logic wrPage;
  wire logic wrPower;
  wire logic wrVendor;
  wire logic wrSpeedLegal;
  wire logic rdIdent;
  wire logic rdVendor;
  wire logic rdPage;
  wire logic rdPower;
  wire logic [7:0] vendorByte;
  wire logic [7:0] readByte;
  wire logic holdActive;
  wire logic pktIsAck;
  wire logic pktLong;
  wire logic clearReq;
  wire logic [1:0] reqRaise;
  // Pending requests, bit 0 fair, bit 1 priority
  logic [1:0] reqPending;

  // Bus front end
  assign takeReq = hsel && hready && htrans[1];
  // Only aligned words in the first 64 bytes map to a register
  assign reqHit = (haddr[31:6] == 26'h0000000) && (haddr[1:0] == 2'h0);
  // Reads take one wait state so a preceding write is always visible
  assign hreadyout = (busState != BUS_RWAIT);
  assign hresp = 1'b0;

  always_comb
  begin
    next_busState = BUS_IDLE;
    unique case (busState)
      BUS_RWAIT:
      begin
        next_busState = BUS_RDONE;
      end
      BUS_IDLE, BUS_WRITE, BUS_RDONE:
      begin
        if (takeReq)
        begin
          next_busState = hwrite ? BUS_WRITE : BUS_RWAIT;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busState <= BUS_IDLE;
    end
    else
    begin
      busState <= next_busState;
    end
  end

  // Address phase kept for use in the data phase
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      addrIdx <= 4'h0;
      addrHit <= 1'b0;
      addrWord <= 1'b0;
    end
    else if (takeReq)
    begin
      addrIdx <= haddr[5:2];
      addrHit <= reqHit;
      addrWord <= (hsize == `PID_HSIZE_WORD);
    end
  end

  // Write decode; partial-width writes are dropped
  assign wrCommit = (busState == BUS_WRITE) && addrHit && addrWord;
  assign wrPage = wrCommit && (addrIdx == `PID_IDX_PAGE_SEL);
  assign wrPower = wrCommit && (addrIdx == `PID_IDX_POWER);
  assign wrVendor = wrCommit &&
    pagedHit(addrIdx, pageSelect, `PID_PAGE_VENDOR, `PID_IDX_VENDOR_CTRL);
  assign wrSpeedLegal =
    hwdata[`PID_SPEED_MSB:`PID_SPEED_LSB] != `PID_SPEED_ILLEGAL;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pageSelect <= `PID_PAGE_RST;
    end
    else if (wrPage)
    begin
      pageSelect <= hwdata[`PID_PAGE_MSB:`PID_PAGE_LSB];
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      nullPacketHold <= `PID_HOLD_RST;
    end
    else if (wrVendor)
    begin
      nullPacketHold <= hwdata[`PID_HOLD_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      linkSpeed <= `PID_SPEED_RST;
    end
    else if (wrVendor && wrSpeedLegal)
    begin
      linkSpeed <= hwdata[`PID_SPEED_MSB:`PID_SPEED_LSB];
    end
  end

  // Straps are sampled by the clock, never by the reset itself
  // Later strap changes take effect only after a new reset
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strapLoaded <= 1'b0;
    end
    else
    begin
      strapLoaded <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      powerClass <= `PID_POWER_RST;
    end
    else if (!strapLoaded)
    begin
      powerClass <= powerClassStraps;
    end
    else if (wrPower)
    begin
      powerClass <= hwdata[`PID_POWER_MSB:`PID_POWER_LSB];
    end
  end

  // Read path
  // identification page
  assign rdIdent = (pageSelect == `PID_PAGE_IDENT) && addrIdx[3];
  assign rdVendor =
    pagedHit(addrIdx, pageSelect, `PID_PAGE_VENDOR, `PID_IDX_VENDOR_CTRL);
  assign rdPage = (addrIdx == `PID_IDX_PAGE_SEL);
  assign rdPower = (addrIdx == `PID_IDX_POWER);
  // Hold bit on top, link speed in the two low bits
  assign vendorByte = {nullPacketHold, 5'h00, linkSpeed};
  assign readByte = !addrHit ? 8'h00 :
    rdIdent ? identByte(addrIdx, MAKER_OUI, PART_CODE) :
    rdVendor ? vendorByte :
    rdPage ? {5'h00, pageSelect} :
    rdPower ? {5'h00, powerClass} :
    8'h00;

  // Loaded in the wait cycle only, so it stands until the next read
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hrdata <= 32'h00000000;
    end
    else if (busState == BUS_RWAIT)
    begin
      hrdata <= {24'h000000, readByte};
    end
  end

  // Request clearing on packet reception
  assign holdActive = nullPacketHold && arbAccelEn;
  // An ACK carries exactly eight data bits
  assign pktIsAck = (pktDataBits == `PID_ACK_BITS);
  assign pktLong = (pktDataBits > `PID_ACK_BITS);
  assign clearReq = pktDone && (holdActive ? pktLong : !pktIsAck);

  assign reqRaise = {prioReqRaise, fairReqRaise};

  // A raise in the clearing cycle wins, so no request is lost
  for (genvar r = 0; r < 2; r++)
  begin : g_req
    always_ff @(posedge mclk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        reqPending[r] <= 1'b0;
      end
      else
      begin
        reqPending[r] <= reqRaise[r] || (reqPending[r] && !clearReq);
      end
    end
  end

  assign fairReqPending = reqPending[0];
  assign prioReqPending = reqPending[1];

  assign selfIdSpeed = linkSpeed;
  assign peerPhySpeed = `PID_PHY_SPEED;
  assign selfIdPower = powerClass;

endmodule

// ---- pid_pkg.sv ----
package pid_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_RWAIT,
    BUS_RDONE
  } pid_bus_state_t;

  typedef logic [1:0] pid_speed_t;
  typedef logic [2:0] pid_power_t;
  typedef logic [2:0] pid_page_t;

endpackage

// ---- pid_regs_props.sv ----
`timescale 1ns/100ps
module pid_regs_props (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic arbAccelEn,
  input wire logic fairReqRaise,
  input wire logic prioReqRaise,
  input wire logic pktDone,
  input wire logic [15:0] pktDataBits,
  input wire logic fairReqPending,
  input wire logic prioReqPending,
  input wire pid_pkg::pid_speed_t selfIdSpeed,
  input wire pid_pkg::pid_speed_t peerPhySpeed,
  input wire pid_pkg::pid_power_t selfIdPower,
  input wire pid_pkg::pid_power_t powerClassStraps
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence takenRd;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence takenWr;
    hsel && hready && htrans[1] && hwrite;
  endsequence
  sequence oneWait;
    !hreadyout ##1 hreadyout;
  endsequence
  chk_read_wait: assert property (takenRd |=> oneWait)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (takenWr |=> hreadyout)
    else $error("write stalled");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  chk_speed_legal: assert property (selfIdSpeed != 2'h3)
    else $error("illegal link speed held");
  chk_prio_raise: assert property (prioReqRaise |=> prioReqPending)
    else $error("priority raise lost");
  chk_peer_fixed: assert property (peerPhySpeed == 2'h2)
    else $error("peer speed not S400");
  chk_strap_load: assert property (!$past(rst_b) |=>
    selfIdPower == $past(powerClassStraps)) else $error("strap not loaded");
  chk_ack_keeps: assert property (pktDone && pktDataBits == 16'h0008 &&
    fairReqPending |=> fairReqPending) else $error("ack cleared request");
  chk_long_clears: assert property (pktDone && pktDataBits > 16'h0008 &&
    !fairReqRaise |=> !fairReqPending) else $error("long packet kept");
  chk_prio_clears: assert property (pktDone && !arbAccelEn &&
    pktDataBits != 16'h0008 && !prioReqRaise |=> !prioReqPending)
    else $error("non-ack packet kept");
  chk_raise_sets: assert property (fairReqRaise |=> fairReqPending)
    else $error("raise lost");
endmodule

// ---- tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  import pid_pkg::*;
  // Arbitrary values
  localparam logic [47:0] IDS = 48'h3C96A5C3695A;
  logic mclk, rst_b, hsel, hwrite, hreadyout, hresp, arbAccelEn;
  logic fairReqRaise, prioReqRaise, pktDone, fairReqPending, prioReqPending;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] pktDataBits;
  wire hready = hreadyout;
  pid_power_t powerClassStraps, selfIdPower;
  pid_page_t pageSelect;
  pid_speed_t selfIdSpeed, peerPhySpeed;
  int miscompares, compares, seed, i;
  pid_phy_id_regs #(.MAKER_OUI(IDS[47:24]), .PART_CODE(IDS[23:0])) DUT (
    .mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .powerClassStraps(powerClassStraps),
    .arbAccelEn(arbAccelEn), .fairReqRaise(fairReqRaise),
    .prioReqRaise(prioReqRaise), .pktDone(pktDone),
    .pktDataBits(pktDataBits), .fairReqPending(fairReqPending),
    .prioReqPending(prioReqPending), .pageSelect(pageSelect),
    .selfIdSpeed(selfIdSpeed), .peerPhySpeed(peerPhySpeed),
    .selfIdPower(selfIdPower));
  pid_llc_model LLC (
    .mclk(mclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    LLC.xfer(a, 1'b1, 3'h2, d, q);
  endtask
  // Byte-size write, which the registers must drop
  task wrb(input logic [31:0] a, input logic [31:0] d);
    LLC.xfer(a, 1'b1, 3'h0, d, q);
  endtask
  task rdc(input logic [31:0] a, input logic [31:0] exp);
    LLC.xfer(a, 1'b0, 3'h2, 32'h0, q);
    chk(q, exp);
  endtask
  // Raise both requests, then one packet of the given length
  task pkt(input logic [15:0] b, input logic keep);
    @(posedge mclk);
    fairReqRaise <= 1'b1;
    prioReqRaise <= 1'b1;
    @(posedge mclk);
    fairReqRaise <= 1'b0;
    prioReqRaise <= 1'b0;
    pktDone <= 1'b1;
    pktDataBits <= b;
    @(posedge mclk);
    pktDone <= 1'b0;
    @(negedge mclk);
    chk({fairReqPending, prioReqPending}, {2{keep}});
    @(posedge mclk);
  endtask
  function automatic logic [31:0] idExp(input int k);
    idExp = k == 8 ? 32'h1 : k == 9 ? 32'h0 : 32'(IDS[47 - 8 * (k - 10) -: 8]);
  endfunction
  task end_sim;
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task do_reset;
    rst_b <= 1'b0;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial
  begin
    #100000;
    miscompares++;
    end_sim;
  end
  initial
  begin
    seed = 66;
    {fairReqRaise, prioReqRaise, pktDone, arbAccelEn} = 4'h0;
    pktDataBits = 16'h0;
    powerClassStraps = 3'($random(seed));
    do_reset;
    chk(32'(selfIdPower), 32'(powerClassStraps));
    wr(32'h1C, 32'h7);
    rdc(32'h1C, 32'h7);
    chk(32'({hresp, pageSelect}), 32'h7);
    rdc(32'h20, 32'h02);
    rdc(32'h24, 32'h0);
    for (i = 0; i < 3; i++)
    begin
      wr(32'h20, {24'h0, i[0], 5'h0, 2'(i)});
      rdc(32'h20, {24'h0, i[0], 5'h0, 2'(i)});
      chk(32'(selfIdSpeed), i);
    end
    wr(32'h20, 32'h83);
    rdc(32'h20, 32'h82);
    chk(32'(peerPhySpeed), 32'h2);
    arbAccelEn <= 1'b1;
    pkt(16'h0, 1'b1);
    pkt(16'h0008, 1'b1);
    pkt(16'h0005, 1'b1);
    pkt(16'h0009, 1'b0);
    arbAccelEn <= 1'b0;
    pkt(16'h0, 1'b0);
    wr(32'h20, 32'h02);
    arbAccelEn <= 1'b1;
    pkt(16'h0, 1'b0);
    pkt(16'h0008, 1'b1);
    pkt(16'h0009 + 16'($random(seed) & 16'hFF), 1'b0);
    for (i = 0; i < 8; i++)
    begin
      wr(32'h10, i);
      rdc(32'h10, i);
      chk(32'(selfIdPower), i);
    end
    wrb(32'h10, 32'h2);
    wr(32'h12, 32'h3);
    wr(32'h50, 32'h4);
    rdc(32'h10, 32'h7);
    rdc(32'h50, 32'h0);
    wr(32'h1C, 32'h1);
    for (i = 8; i < 16; i++)
      rdc(32'(4 * i), idExp(i));
    wr(32'h04, $random(seed));
    rdc(32'h04, 32'h0);
    wr(32'h1C, 32'h7);
    wr(32'h20, 32'h80);
    powerClassStraps <= 3'($random(seed));
    do_reset;
    chk(32'(selfIdPower), 32'(powerClassStraps));
    rdc(32'h10, 32'(powerClassStraps));
    wr(32'h1C, 32'h7);
    rdc(32'h20, 32'h02);
    end_sim;
  end
endmodule
bind pid_phy_id_regs pid_regs_props CHK (
  .mclk(mclk), .rst_b(rst_b), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .arbAccelEn(arbAccelEn), .fairReqRaise(fairReqRaise),
  .prioReqRaise(prioReqRaise), .pktDone(pktDone),
  .pktDataBits(pktDataBits), .fairReqPending(fairReqPending),
  .prioReqPending(prioReqPending), .selfIdSpeed(selfIdSpeed),
  .peerPhySpeed(peerPhySpeed), .selfIdPower(selfIdPower),
  .powerClassStraps(powerClassStraps));
